// File: include/fcpd_map.svh
// register-free constants for the floppy command parameter decoder
`ifndef FCPD_MAP_SVH
`define FCPD_MAP_SVH
`define FCPD_BASE_SECTOR_BYTES   17'h00080
`define FCPD_MAX_SIZE_CODE       3'h7
`define FCPD_QUEUE_EN_LOW_DEF    1'b1
`define FCPD_QUEUE_THR_DEF       4'h0
`define FCPD_PRECOMP_TRK_DEF     8'h00
`define FCPD_LOAD_UNIT_NS        1000
`define FCPD_CLK_PERIOD_NS       5
`define FCPD_LOAD_UNIT_CYC       ((`FCPD_LOAD_UNIT_NS + `FCPD_CLK_PERIOD_NS - 1) / `FCPD_CLK_PERIOD_NS)
`endif

// File: include/fcpd_pkg.sv
// types for the floppy command parameter decoder
package fcpd_pkg;
    typedef struct packed {
        logic       density_mfm;
        logic       cylinder_span_flag;
        logic       head_select;
        logic [1:0] drive_select_bits;
        logic [2:0] size_code;
        logic [7:0] short_sector_length;
        logic [7:0] intersector_gap_length;
        logic [7:0] perp_gap_length;
        logic [7:0] target_cylinder;
    } fcpd_cmd_t;

    typedef struct packed {
        logic       queue_enable_low;
        logic [3:0] queue_threshold;
        logic [7:0] precomp_start_track;
    } fcpd_cfg_t;

    typedef enum logic [1:0] {
        HD_IDLE    = 2'b00,
        HD_LOADING = 2'b01,
        HD_ACTIVE  = 2'b10,
        HD_HOLD    = 2'b11
    } fcpd_head_t;
endpackage : fcpd_pkg

// File: rtl/fcpd_decode.sv
// floppy command parameter decoder with head load/unload timing
`include "fcpd_map.svh"
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [RULE1] density bit one MFM, zero FM
// [RULE2] span flag continues head 0 into head 1
// [RULE3] sector bytes 128 shifted by code
// [RULE4] code zero: 128 bytes, length from short
// [RULE5] host avoids impossible size combinations
// [RULE6] head select picks disk side
// [RULE7] wait head load time before transfer
// [RULE8] hold head for unload time after execution
// [RULE9] gap length sets gap 3 size
// [RULE10] perpendicular mode sets gap 2 length
// [RULE11] lock governs soft reset of configuration
// [RULE12] locked config survives soft reset
// [RULE13] short sector: discard on read, zero-fill write
// [RULE14] two select bits choose one of four drives
module fcpd_decode #(
    parameter int LOAD_UNIT_CYC = `FCPD_LOAD_UNIT_CYC
) (
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    input  wire logic              i_cmd_load,
    input  wire fcpd_pkg::fcpd_cmd_t i_cmd,
    input  wire logic              i_perp_mode,
    input  wire logic              i_cfg_load,
    input  wire fcpd_pkg::fcpd_cfg_t i_cfg,
    input  wire logic              i_lock_load,
    input  wire logic              i_lock,
    input  wire logic              i_soft_reset,
    input  wire logic [7:0]        i_head_load_time,
    input  wire logic [7:0]        i_head_unload_time,
    input  wire logic              i_exec_start,
    input  wire logic              i_exec_end,
    input  wire logic              i_last_sector,
    input  wire logic              i_write_mode,
    input  wire logic [16:0]       i_byte_index,
    output logic                   o_mfm,
    output logic                   o_side,
    output logic [3:0]             o_drive_onehot,
    output logic [16:0]            o_sector_bytes,
    output logic [16:0]            o_xfer_bytes,
    output logic [7:0]             o_gap3_len,
    output logic [7:0]             o_gap2_len,
    output logic [7:0]             o_target_cylinder,
    output logic                   o_head_loaded,
    output logic                   o_xfer_ready,
    output logic                   o_pass_to_host,
    output logic                   o_zero_fill,
    output logic                   o_track_done,
    output logic                   o_lock,
    output fcpd_pkg::fcpd_cfg_t    o_cfg
);
    fcpd_pkg::fcpd_cmd_t  cmd_reg;
    fcpd_pkg::fcpd_head_t head_reg;
    logic [7:0]           tick_reg;
    logic [15:0]          unit_reg;
    logic [16:0]          size_next;
    logic [16:0]          xfer_next;
    logic                 unit_tick;

    // sector size from code, limited to the top code
    always_comb begin
        logic [2:0] code;
        code = cmd_reg.size_code;
        if (code > `FCPD_MAX_SIZE_CODE) begin
            code = `FCPD_MAX_SIZE_CODE;
        end
        size_next = `FCPD_BASE_SECTOR_BYTES << code; // [RULE3]
        if (code == 3'h0) begin
            xfer_next = {9'h000, cmd_reg.short_sector_length}; // [RULE4]
        end else begin
            xfer_next = size_next;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cmd_reg <= '0;
        end else if (i_cmd_load) begin
            cmd_reg <= i_cmd;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_mfm             <= 1'b0;
            o_side            <= 1'b0;
            o_drive_onehot    <= 4'h1;
            o_sector_bytes    <= `FCPD_BASE_SECTOR_BYTES;
            o_xfer_bytes      <= 17'h00000;
            o_gap3_len        <= 8'h00;
            o_gap2_len        <= 8'h00;
            o_target_cylinder <= 8'h00;
        end else begin
            o_mfm             <= cmd_reg.density_mfm; // [RULE1]
            o_drive_onehot    <= 4'h1 << cmd_reg.drive_select_bits; // [RULE14]
            o_sector_bytes    <= size_next;
            o_xfer_bytes      <= xfer_next;
            o_gap3_len        <= cmd_reg.intersector_gap_length; // [RULE9]
            o_gap2_len        <= i_perp_mode ? cmd_reg.perp_gap_length : 8'h00; // [RULE10]
            o_target_cylinder <= cmd_reg.target_cylinder;
            // side follows head select, advanced by span at end of head 0
            if (i_cmd_load) begin
                o_side <= i_cmd.head_select; // [RULE6]
            end else if (i_last_sector && cmd_reg.cylinder_span_flag && !o_side) begin
                o_side <= 1'b1; // [RULE2]
            end
        end
    end

    // end of track: span flag makes head 1's last sector the end
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_track_done <= 1'b0;
        end else begin
            o_track_done <= i_last_sector && (!cmd_reg.cylinder_span_flag || o_side); // [RULE2]
        end
    end

    // short sector handling beyond the special length
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pass_to_host <= 1'b0;
            o_zero_fill    <= 1'b0;
        end else begin
            o_pass_to_host <= !i_write_mode && (i_byte_index < xfer_next); // [RULE13]
            o_zero_fill    <= i_write_mode && (i_byte_index >= xfer_next); // [RULE13]
        end
    end

    // configuration retained across soft reset while locked
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_lock <= 1'b0;
            o_cfg  <= '{`FCPD_QUEUE_EN_LOW_DEF, `FCPD_QUEUE_THR_DEF, `FCPD_PRECOMP_TRK_DEF};
        end else begin
            if (i_lock_load) begin
                o_lock <= i_lock;
            end
            if (i_cfg_load) begin
                o_cfg <= i_cfg;
            end else if (i_soft_reset && !o_lock) begin // [RULE11]
                o_cfg <= '{`FCPD_QUEUE_EN_LOW_DEF, `FCPD_QUEUE_THR_DEF,
                           `FCPD_PRECOMP_TRK_DEF}; // [RULE12]
            end
        end
    end

    // time base: one tick per load unit
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            unit_reg <= 16'h0000;
        end else if (head_reg == fcpd_pkg::HD_LOADING || head_reg == fcpd_pkg::HD_HOLD) begin
            if (unit_tick) begin
                unit_reg <= 16'h0000;
            end else begin
                unit_reg <= unit_reg + 16'h0001;
            end
        end else begin
            unit_reg <= 16'h0000;
        end
    end
    assign unit_tick = (unit_reg == 16'(LOAD_UNIT_CYC - 1));

    // head load / unload sequencing
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            head_reg      <= fcpd_pkg::HD_IDLE;
            tick_reg      <= 8'h00;
            o_head_loaded <= 1'b0;
            o_xfer_ready  <= 1'b0;
        end else begin
            case (head_reg)
                fcpd_pkg::HD_IDLE: begin
                    o_xfer_ready <= 1'b0;
                    if (i_exec_start) begin
                        head_reg      <= fcpd_pkg::HD_LOADING;
                        tick_reg      <= i_head_load_time;
                        o_head_loaded <= 1'b1;
                    end
                end
                fcpd_pkg::HD_LOADING: begin
                    if (tick_reg == 8'h00) begin
                        head_reg     <= fcpd_pkg::HD_ACTIVE;
                        o_xfer_ready <= 1'b1; // [RULE7]
                    end else if (unit_tick) begin
                        tick_reg <= tick_reg - 8'h01; // [RULE7]
                    end
                end
                fcpd_pkg::HD_ACTIVE: begin
                    if (i_exec_end) begin
                        head_reg     <= fcpd_pkg::HD_HOLD;
                        tick_reg     <= i_head_unload_time;
                        o_xfer_ready <= 1'b0;
                    end
                end
                fcpd_pkg::HD_HOLD: begin
                    if (i_exec_start) begin
                        head_reg     <= fcpd_pkg::HD_ACTIVE;
                        o_xfer_ready <= 1'b1;
                    end else if (tick_reg == 8'h00) begin
                        head_reg      <= fcpd_pkg::HD_IDLE;
                        o_head_loaded <= 1'b0; // [RULE8]
                    end else if (unit_tick) begin
                        tick_reg <= tick_reg - 8'h01; // [RULE8]
                    end
                end
                default: begin
                    head_reg <= fcpd_pkg::HD_IDLE;
                end
            endcase
        end
    end
endmodule : fcpd_decode
`default_nettype wire

// File: tb/fcpd_checker.sv
// port-level assertions for the command parameter decoder
`timescale 1ns/1ps
`default_nettype none
module fcpd_checker #(
    parameter int LOAD_UNIT_CYC = 2
) (
    input wire logic                i_clk,
    input wire logic                i_reset_n,
    input wire logic                i_cmd_load,
    input wire fcpd_pkg::fcpd_cmd_t i_cmd,
    input wire logic                i_perp_mode,
    input wire logic                i_cfg_load,
    input wire logic                i_soft_reset,
    input wire logic [7:0]          i_head_load_time,
    input wire logic [7:0]          i_head_unload_time,
    input wire logic                o_mfm,
    input wire logic                o_side,
    input wire logic [3:0]          o_drive_onehot,
    input wire logic [16:0]         o_sector_bytes,
    input wire logic [7:0]          o_gap3_len,
    input wire logic [7:0]          o_gap2_len,
    input wire logic                o_head_loaded,
    input wire logic                o_xfer_ready,
    input wire logic                o_track_done,
    input wire logic                o_lock,
    input wire fcpd_pkg::fcpd_cfg_t o_cfg
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    int cnt;
    // cycles with head loaded but no transfer permitted
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt <= 0;
        end else if (!o_head_loaded || o_xfer_ready) begin
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
    a_mfm_select: assert property (i_cmd_load |-> ##2 o_mfm == $past(i_cmd.density_mfm, 2))
        else $error("density output wrong");
    a_side_select: assert property (i_cmd_load |=> o_side == $past(i_cmd.head_select))
        else $error("side output wrong");
    a_drive_select: assert property (i_cmd_load |-> ##2
        o_drive_onehot == 4'h1 << $past(i_cmd.drive_select_bits, 2)) else $error("drive wrong");
    a_sector_size: assert property (i_cmd_load |-> ##2
        o_sector_bytes == 17'h00080 << $past(i_cmd.size_code, 2)) else $error("size wrong");
    a_gap3_len: assert property (i_cmd_load |-> ##2
        o_gap3_len == $past(i_cmd.intersector_gap_length, 2)) else $error("gap3 wrong");
    a_gap2_len: assert property (i_cmd_load && i_perp_mode |-> ##2
        o_gap2_len == $past(i_cmd.perp_gap_length, 2)) else $error("gap2 wrong");
    a_load_wait: assert property ($rose(o_xfer_ready) |->
        cnt >= i_head_load_time * LOAD_UNIT_CYC - 1) else $error("transfer before load time");
    a_unload_hold: assert property ($fell(o_head_loaded) |->
        $past(cnt) >= i_head_unload_time * LOAD_UNIT_CYC - 2) else $error("early unload");
    a_lock_keep: assert property (i_soft_reset && o_lock && !i_cfg_load |=>
        o_cfg == $past(o_cfg)) else $error("locked config changed");
    a_lock_clear: assert property (i_soft_reset && !o_lock && !i_cfg_load |=>
        o_cfg == 13'h1000) else $error("config not defaulted");
    a_track_pulse: assert property (o_track_done |=> !o_track_done)
        else $error("track done too long");
endmodule : fcpd_checker
bind fcpd_decode fcpd_checker #(.LOAD_UNIT_CYC(LOAD_UNIT_CYC)) u_chk (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_cmd_load(i_cmd_load), .i_cmd(i_cmd),
    .i_perp_mode(i_perp_mode), .i_cfg_load(i_cfg_load), .i_soft_reset(i_soft_reset),
    .i_head_load_time(i_head_load_time), .i_head_unload_time(i_head_unload_time),
    .o_mfm(o_mfm), .o_side(o_side), .o_drive_onehot(o_drive_onehot),
    .o_sector_bytes(o_sector_bytes), .o_gap3_len(o_gap3_len), .o_gap2_len(o_gap2_len),
    .o_head_loaded(o_head_loaded), .o_xfer_ready(o_xfer_ready),
    .o_track_done(o_track_done), .o_lock(o_lock), .o_cfg(o_cfg));
`default_nettype wire

// File: tb/fcpd_drive_model.sv
// drive model: streams byte positions, flags each sector end
`timescale 1ns/1ps
`default_nettype none
module fcpd_drive_model (
    input  wire logic        i_clk,
    input  wire logic        i_ready,
    input  wire logic [16:0] i_sector_bytes,
    output logic [16:0]      o_byte_index,
    output logic             o_last_sector
);
    logic end_of_sector;
    assign end_of_sector = i_ready && o_byte_index == i_sector_bytes - 17'h00001;
    initial o_byte_index = 17'h00000;
    initial o_last_sector = 1'b0;
    // changes by non-blocking assignment on the edge, so no race with the bench
    always @(posedge i_clk) begin
        o_last_sector <= end_of_sector;
        o_byte_index  <= (i_ready && !end_of_sector) ? o_byte_index + 17'h00001 : 17'h00000;
    end
endmodule : fcpd_drive_model
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the command parameter decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int LU = 2;
    logic clk = 1'b0, rst_n, cl, pm, fl, ll, lk_in, sr, xs, xe, wr, last, mfm, side, hl, xr;
    logic pass, zf, td, lk;
    logic [3:0] drv;
    logic [7:0] head_load_time, head_unload_time, g3, g2, tcyl;
    logic [16:0] idx, sb, xb;
    fcpd_pkg::fcpd_cmd_t c;
    fcpd_pkg::fcpd_cfg_t cfg, ocfg;
    int error_cnt = 0, checked = 0, cyc = 0, n;
    always #2.5 clk = ~clk;
    fcpd_decode #(.LOAD_UNIT_CYC(LU)) u_dut (
        .i_clk(clk), .i_reset_n(rst_n), .i_cmd_load(cl), .i_cmd(c), .i_perp_mode(pm),
        .i_cfg_load(fl), .i_cfg(cfg), .i_lock_load(ll), .i_lock(lk_in), .i_soft_reset(sr),
        .i_head_load_time(head_load_time), .i_head_unload_time(head_unload_time), .i_exec_start(xs),
        .i_exec_end(xe), .i_last_sector(last), .i_write_mode(wr), .i_byte_index(idx),
        .o_mfm(mfm), .o_side(side), .o_drive_onehot(drv), .o_sector_bytes(sb),
        .o_xfer_bytes(xb), .o_gap3_len(g3), .o_gap2_len(g2), .o_target_cylinder(tcyl),
        .o_head_loaded(hl), .o_xfer_ready(xr), .o_pass_to_host(pass), .o_zero_fill(zf),
        .o_track_done(td), .o_lock(lk), .o_cfg(ocfg));
    fcpd_drive_model u_drive (.i_clk(clk), .i_ready(xr), .i_sector_bytes(sb),
        .o_byte_index(idx), .o_last_sector(last));
    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step
    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
    endtask : pulse
    task automatic results();
        $display("checks=%0d errors=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            results();
        end
    end
    initial begin
        {rst_n, cl, pm, fl, ll, lk_in, sr, xs, xe, wr} = '0;
        c = '0;
        cfg = '0;
        head_load_time = 8'h03;
        head_unload_time = 8'h04;
        step(3);
        rst_n = 1'b1;
        for (int k = 0; k < 8; k++) begin
            c = {k[0], 1'b0, k[1], k[1:0], k[2:0], 8'h10, 8'h1b ^ k[7:0], 8'h20 | k[7:0], 8'h40};
            pm = k[0];
            pulse(cl);
            step(2);
            chk(mfm, k[0]);
            chk(side, k[1]);
            chk(drv, 4'h1 << k[1:0]);
            chk(sb, 17'h00080 << k[2:0]);
            chk(xb, k == 0 ? 17'h00010 : 17'h00080 << k[2:0]);
            chk(g3, c.intersector_gap_length);
            chk(g2, k[0] ? c.perp_gap_length : 8'h00);
            chk(tcyl, 8'h40);
        end
        cfg = {1'b0, 4'h5, 8'h33};
        pulse(fl);
        pulse(sr);
        step(1);
        chk(ocfg, 13'h1000);
        pulse(fl);
        lk_in = 1'b1;
        pulse(ll);
        pulse(sr);
        step(1);
        chk(ocfg, 13'h0533);
        c = {1'b1, 1'b1, 1'b0, 2'b00, 3'h0, 8'h04, 8'h1b, 8'h00, 8'h00};
        pm = 1'b0;
        pulse(cl);
        step(2);
        pulse(xs);
        for (n = 0; xr !== 1'b1; n++) step(1);
        chk(n >= head_load_time * LU - 1 && n <= head_load_time * LU + 3, 1'b1);
        while (idx !== 17'h00002) step(1);
        chk(pass, 1'b1);
        while (idx !== 17'h0000a) step(1);
        chk(pass, 1'b0);
        while (side !== 1'b1) step(1);
        chk(td, 1'b0);
        wr = 1'b1;
        while (idx !== 17'h0000a) step(1);
        chk(zf, 1'b1);
        while (td !== 1'b1) step(1);
        pulse(xe);
        for (n = 0; hl !== 1'b0; n++) step(1);
        chk(n >= head_unload_time * LU - 2 && n <= head_unload_time * LU + 3, 1'b1);
        results();
    end
endmodule : tb_top
`default_nettype wire
